// ---- dv/mecnt_enc_src.sv ----
// Encoder and pulse source model standing at the counter inputs
`timescale 1ns/1ns
module mecnt_enc_src (
   input wire logic mclk_in,
   output logic phase_a_out,
   output logic phase_b_out,
   output logic index_out
);
   int ph = 0;
   int gap = 8;
   time t_rise = 0;
   // Idle lines rest low until the sensor moves
   initial begin
      phase_a_out = 1'b0;
      phase_b_out = 1'b0;
      index_out = 1'b0;
   end
   // Quadrature walk 00,10,11,01; gap sets how slowly the shaft turns
   task automatic step(input int dir);
      ph = (ph + dir + 4) % 4;
      @(posedge mclk_in);
      phase_a_out <= (ph == 1 || ph == 2);
      phase_b_out <= (ph >= 2);
      repeat (gap) @(posedge mclk_in);
   endtask
   // One high pulse on A (sel 0) or B (sel 1), width in clocks
   task automatic pulse(input int sel, input int w);
      @(posedge mclk_in);
      phase_a_out <= (sel == 0);
      phase_b_out <= (sel == 1);
      t_rise = $time;
      repeat (w) @(posedge mclk_in);
      phase_a_out <= 1'b0;
      phase_b_out <= 1'b0;
      repeat (gap) @(posedge mclk_in);
   endtask
   // Index mark held while the shaft rests
   task automatic zpulse(input int w);
      @(posedge mclk_in);
      index_out <= 1'b1;
      repeat (w) @(posedge mclk_in);
      index_out <= 1'b0;
      repeat (gap) @(posedge mclk_in);
   endtask
endmodule

// ---- dv/mecnt_top_sva.sv ----
// Port-level assertions for the multimode encoder counter
`timescale 1ns/1ns
module mecnt_top_sva (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic sample_clk_in,
   input wire logic acq_start_in,
   input wire logic [mecnt_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [mecnt_pkg::CNT_W-1:0] count_out,
   input wire logic [mecnt_pkg::CNT_W-1:0] time_out,
   input wire logic sample_valid_out
);
   import mecnt_pkg::*;
   logic [11:0] ctrl_ff;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   // Shadow of the control word, so reads and the mode can be judged
   always_ff @(posedge mclk_in) begin
      if (!resetn_in)
         ctrl_ff <= 12'h000;
      else if (reg_wr_in && reg_addr_in == CTRL_OFS)
         ctrl_ff <= reg_wdata_in[11:0];
   end
   a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data outside its slot");
   a_ctrl_readback: assert property (reg_rd_in && reg_addr_in == CTRL_OFS
      |=> reg_rdata_out == {20'h0, $past(ctrl_ff)}) else $error("control readback wrong");
   a_unmapped_zero: assert property (reg_rd_in && reg_addr_in[1:0] != 2'b00
      |=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
   a_status_upper: assert property (reg_rd_in && reg_addr_in == STATUS_OFS
      |=> reg_rdata_out[31:5] == 27'h0) else $error("status spare bits set");
   a_valid_single: assert property (sample_valid_out |=> !sample_valid_out)
      else $error("sample valid longer than one cycle");
   a_sample_answer: assert property ($rose(sample_clk_in) |-> ##[2:6] sample_valid_out)
      else $error("sample clock not answered");
   a_valid_cause: assert property (sample_valid_out
      |-> $past(sample_clk_in, 3) || $past(sample_clk_in, 4)) else $error("valid without sample");
   a_outputs_hold: assert property (!sample_valid_out && !$past(acq_start_in)
      |-> $stable(count_out) && $stable(time_out)) else $error("output moved between samples");
   a_time_nonfreq: assert property (sample_valid_out && ctrl_ff[2:0] != MECNT_FREQ
      |-> time_out == 32'h0) else $error("time output outside frequency mode");
endmodule
bind mecnt_top mecnt_top_sva chk_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
   .sample_clk_in(sample_clk_in), .acq_start_in(acq_start_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .count_out(count_out), .time_out(time_out),
   .sample_valid_out(sample_valid_out));

// ---- dv/tb.sv ----
// Self-checking bench for the multimode encoder counter
`timescale 1ns/1ns
module tb;
   import mecnt_pkg::*;
   logic mclk_in = 1'b0;
   logic resetn = 1'b0;
   logic sclk = 1'b0;
   logic acq = 1'b0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, cnt, tim, c, t;
   logic valid, pa, pb, pz;
   int err_total = 0;
   int cmp_count = 0;
   int m, n, k;
   time ts;
   mecnt_top dut_u (.mclk_in(mclk_in), .resetn_in(resetn), .phase_a_in(pa), .phase_b_in(pb),
      .index_in(pz), .sample_clk_in(sclk), .acq_start_in(acq), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
      .count_out(cnt), .time_out(tim), .sample_valid_out(valid));
   mecnt_enc_src src_u (.mclk_in(mclk_in), .phase_a_out(pa), .phase_b_out(pb), .index_out(pz));
   // 250 MHz clock
   initial begin
      forever #2 mclk_in = ~mclk_in;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Time base counts carry one tick of phase slack, plus the sync latency
   task automatic near(input logic [31:0] g, input int e, input int tol);
      cmp_count++;
      if ($isunknown(g) || $signed(g) > e + tol || $signed(g) < e - tol) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk_in);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk_in);
      rd_s <= 1'b0;
      @(negedge mclk_in);
      d = rdata;
   endtask
   task automatic go();
      @(posedge mclk_in);
      acq <= 1'b1;
      ts = $time;
      @(posedge mclk_in);
      acq <= 1'b0;
   endtask
   // Sample pulse is held long enough to pass the synchroniser cleanly
   task automatic smp(output logic [31:0] cv, output logic [31:0] tv);
      int w;
      w = 0;
      @(posedge mclk_in);
      sclk <= 1'b1;
      do begin
         @(negedge mclk_in);
         w++;
      end while (valid !== 1'b1 && w < 20);
      chk({31'h0, valid}, 32'h1);
      cv = cnt;
      tv = tim;
      repeat (6) @(posedge mclk_in);
      sclk <= 1'b0;
      repeat (6) @(posedge mclk_in);
   endtask
   // Reference decoder: counts depend on the phase the step leaves
   task automatic mv(input int md, input int dir);
      int p;
      p = src_u.ph;
      if (dir > 0)
         m += (md == 2 || p == 0 || (md == 1 && p == 2));
      else
         m -= (md == 2 || p == 1 || (md == 1 && p == 3));
      src_u.step(dir);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog well beyond the expected run of at most about 3.5k cycles
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(75));
      repeat (3) @(posedge mclk_in);
      resetn <= 1'b1;
      rd(CTRL_OFS, c);
      chk(c, 32'h0);
      n = $urandom;
      wr(CTRL_OFS, n);
      rd(CTRL_OFS, c);
      chk(c, {20'h0, n[11:0]});
      rd(4'h2, c);
      chk(c, 32'h0);
      $display("done registers");
      for (int md = 0; md < 3; md++) begin
         wr(CTRL_OFS, 32'(md));
         go();
         m = 0;
         repeat ($urandom_range(12, 4)) mv(md, 1);
         smp(c, t);
         chk(c, 32'(m));
         repeat ($urandom_range(16, 1)) mv(md, -1);
         smp(c, t);
         chk(c, 32'(m));
         rd(COUNT_OFS, c);
         chk(c, 32'(m));
         $display("done decode mode %0d", md);
      end
      wr(CTRL_OFS, 32'h802);
      while (src_u.ph != 0) mv(2, 1);
      src_u.zpulse(10);
      m = 0;
      repeat (3) mv(2, 1);
      smp(c, t);
      chk(c, 32'(m));
      $display("done index");
      src_u.gap = 40;
      wr(CTRL_OFS, 32'h013);
      go();
      n = $urandom_range(6, 2);
      k = $urandom_range(6, 1);
      repeat (n) src_u.pulse(0, 30);
      repeat (k) src_u.pulse(1, 30);
      src_u.pulse(0, 15);
      smp(c, t);
      chk(c, 32'(n - k));
      wr(CTRL_OFS, 32'h213);
      go();
      src_u.pulse(0, 30);
      smp(c, t);
      chk(c, 32'(n - k + 1));
      wr(CTRL_OFS, 32'h023);
      go();
      src_u.pulse(0, 60);
      src_u.pulse(1, 40);
      smp(c, t);
      chk(c, 32'h1);
      $display("done pulse and filter");
      src_u.gap = 20;
      for (int d = 0; d < 2; d++) begin
         wr(CTRL_OFS, 32'h004 | 32'(d << 8));
         go();
         n = $urandom_range(9, 3);
         repeat (n) src_u.pulse(0, 10);
         smp(c, t);
         chk(c, 32'(d ? -n : n));
         near(t, int'((src_u.t_rise - ts) * 2 / 25), 4);
         rd(TIME_OFS, c);
         near(c, int'((src_u.t_rise - ts) * 2 / 25), 4);
      end
      $display("done frequency");
      src_u.gap = 89;
      for (int z = 0; z < 2; z++) begin
         wr(CTRL_OFS, 32'h005 | 32'(z << 10));
         go();
         repeat (3) src_u.pulse(0, 10);
         rd(STATUS_OFS, c);
         chk(c, 32'h10);
         smp(c, t);
         near(c, 32, 2);
         smp(c, t);
         if (z)
            chk(c, 32'h0);
         else
            near(c, 32, 2);
      end
      $display("done period");
      tally_and_finish();
   end
endmodule

// ---- hdl/mecnt_top.sv ----
// Multimode encoder counter channel: decode, filter, frequency and period
`timescale 1ns/1ns
module mecnt_top (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic phase_a_in,
   input wire logic phase_b_in,
   input wire logic index_in,
   input wire logic sample_clk_in,
   input wire logic acq_start_in,
   input wire logic [mecnt_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic [mecnt_pkg::CNT_W-1:0] count_out,
   output logic [mecnt_pkg::CNT_W-1:0] time_out,
   output logic sample_valid_out
);
   import mecnt_pkg::*;

   // Control fields
   logic [11:0] ctrl_ff;
   mecnt_mode_e mode;
   logic [2:0] filt_sel;
   logic dir_down;
   logic no_clear;
   logic zero_opt;
   logic index_en;
   // Input conditioning
   logic [2:0] raw_in;
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic [2:0] sync3_ff;
   logic [2:0] clean_ff;
   logic smp1_ff;
   logic smp2_ff;
   logic smp3_ff;
   logic smp_lvl_ff;
   logic smp_tick;
   logic [8:0] tb_acc_ff;
   logic tb_tick;
   logic [GATE_W-1:0] gate_ticks;
   logic [2:0] filt_out_ff;
   logic [2:0] filt_lvl;
   // Decoder
   logic [2:0] prev_ff;
   logic a;
   logic b;
   logic z;
   logic a_prev;
   logic b_prev;
   logic a_rise;
   logic a_fall;
   logic b_rise;
   logic b_edge;
   logic a_edge;
   logic step_up;
   logic step_dn;
   logic index_hit;
   // Counters and captures
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   logic [CNT_W-1:0] tb_count_ff;
   logic [CNT_W-1:0] tb_latch_ff;
   logic [CNT_W-1:0] period_ff;
   logic [CNT_W-1:0] period_latch_ff;
   logic period_armed_ff;
   logic period_new_ff;
   logic clear_now;

   // Control field decode
   assign mode = mecnt_mode_e'(ctrl_ff[CTRL_MODE_LSB +: 3]);
   assign filt_sel = ctrl_ff[CTRL_FILT_LSB +: 3];
   assign dir_down = ctrl_ff[CTRL_DOWN_BIT];
   assign no_clear = ctrl_ff[CTRL_NOCLR_BIT];
   assign zero_opt = ctrl_ff[CTRL_ZERO_BIT];
   assign index_en = ctrl_ff[CTRL_INDEX_BIT];

   // Control register write; only the low twelve bits are kept
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ctrl_ff <= CTRL_RESET;
      end else if (reg_wr_in && reg_addr_in == CTRL_OFS) begin
         ctrl_ff <= reg_wdata_in[11:0];
      end
   end

   // Register read, data valid in the cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 32'h0;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            CTRL_OFS: reg_rdata_out <= {20'h0, ctrl_ff};
            COUNT_OFS: reg_rdata_out <= count_ff;
            TIME_OFS: reg_rdata_out <= tb_latch_ff;
            STATUS_OFS: reg_rdata_out <= {27'h0, period_new_ff, filt_lvl, 1'b0};
            default: reg_rdata_out <= 32'h0;
         endcase
      end else begin
         reg_rdata_out <= 32'h0;
      end
   end

   // Pin inputs pass three flops; a change is taken once stages two and
   // three agree, so metastable values on stage one never reach logic
   assign raw_in = {index_in, phase_b_in, phase_a_in};
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
         sync3_ff <= 3'h0;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // Agreed level per input
   // The agreed stage costs a cycle of latency, but a one-cycle disagreement
   // between stages two and three can never produce a false edge
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         clean_ff <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sync2_ff[i] == sync3_ff[i]) begin
               clean_ff[i] <= sync3_ff[i];
            end
         end
      end
   end

   // Sample clock arrives from the acquisition side, same treatment
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         smp1_ff <= 1'b0;
         smp2_ff <= 1'b0;
         smp3_ff <= 1'b0;
         smp_lvl_ff <= 1'b0;
      end else begin
         smp1_ff <= sample_clk_in;
         smp2_ff <= smp1_ff;
         smp3_ff <= smp2_ff;
         if (smp2_ff == smp3_ff) begin
            smp_lvl_ff <= smp3_ff;
         end
      end
   end
   assign smp_tick = smp2_ff && smp3_ff && !smp_lvl_ff;

   // Time base tick at 80 MHz from the 250 MHz clock by a rate accumulator.
   // Ticks jitter by one clock but average exactly 12.5 ns
   // One clock domain only: a tick pulse replaces a divided clock
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         tb_acc_ff <= 9'h0;
      end else if (tb_acc_ff + 9'(TB_KHZ / 1000) >= 9'(CLK_KHZ / 1000)) begin
         tb_acc_ff <= tb_acc_ff + 9'(TB_KHZ / 1000) - 9'(CLK_KHZ / 1000);
      end else begin
         tb_acc_ff <= tb_acc_ff + 9'(TB_KHZ / 1000);
      end
   end
   assign tb_tick = (tb_acc_ff + 9'(TB_KHZ / 1000) >= 9'(CLK_KHZ / 1000));

   // Gate time in time base ticks for the selected setting
   always_comb begin
      gate_ticks = '0;
      for (int g = 0; g < 8; g++) begin
         if (filt_sel == 3'(g)) begin
            gate_ticks = GATE_W'(GATE_NS[g] * 1000 / TB_PERIOD_PS);
         end
      end
   end

   // One filter per input; the stability count restarts whenever the input
   // returns to the passed level, so short pulses never get through
   for (genvar gi = 0; gi < 3; gi++) begin : g_filt
      logic [GATE_W-1:0] stable_ff;
      always_ff @(posedge mclk_in) begin
         if (!resetn_in) begin
            stable_ff <= '0;
            filt_out_ff[gi] <= 1'b0;
         end else if (tb_tick) begin
            if (clean_ff[gi] == filt_out_ff[gi]) begin
               stable_ff <= '0;
            end else if (stable_ff + GATE_W'(1) >= gate_ticks) begin
               filt_out_ff[gi] <= clean_ff[gi];
               stable_ff <= '0;
            end else begin
               stable_ff <= stable_ff + GATE_W'(1);
            end
         end
      end
      // Off setting bypasses the filter completely
      assign filt_lvl[gi] = (filt_sel == 3'h0) ? clean_ff[gi] : filt_out_ff[gi];
   end

   // Previous filtered levels for edge detection
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         prev_ff <= 3'h0;
      end else begin
         prev_ff <= filt_lvl;
      end
   end

   assign a = filt_lvl[0];
   assign b = filt_lvl[1];
   assign z = filt_lvl[2];
   assign a_prev = prev_ff[0];
   assign b_prev = prev_ff[1];
   assign a_rise = a && !a_prev;
   assign a_fall = !a && a_prev;
   assign a_edge = a ^ a_prev;
   assign b_rise = b && !b_prev;
   assign b_edge = b ^ b_prev;

   // Decoder steps. For quadrature, direction is up when new A differs from
   // old B, which covers A leading B on every edge kind
   always_comb begin
      step_up = 1'b0;
      step_dn = 1'b0;
      case (mode)
         MECNT_SINGLE: begin
            step_up = a_rise && !b;
            step_dn = a_fall && !b;
         end
         MECNT_DOUBLE: begin
            step_up = a_edge && (a ^ b_prev);
            step_dn = a_edge && !(a ^ b_prev);
         end
         MECNT_QUAD: begin
            step_up = (a_edge ^ b_edge) && (a ^ b_prev);
            step_dn = (a_edge ^ b_edge) && !(a ^ b_prev);
         end
         MECNT_PULSE: begin
            step_up = a_rise && !b_rise;
            step_dn = b_rise && !a_rise;
         end
         MECNT_FREQ: begin
            step_up = a_rise && !dir_down;
            step_dn = a_rise && dir_down;
         end
         default: begin
            step_up = 1'b0;
            step_dn = 1'b0;
         end
      endcase
   end

   // Index reloads zero in the quarter where A and B are both low
   assign index_hit = index_en && z && !a && !b &&
      (mode == MECNT_SINGLE || mode == MECNT_DOUBLE || mode == MECNT_QUAD);

   // Start of acquisition clears unless the channel keeps its position
   assign clear_now = acq_start_in && !no_clear;

   // Event or position counter (even counter of the pair)
   always_comb begin
      nxt_count = count_ff;
      if (clear_now || index_hit) begin
         nxt_count = '0;
      end else if (step_up) begin
         nxt_count = count_ff + CNT_W'(1);
      end else if (step_dn) begin
         nxt_count = count_ff - CNT_W'(1);
      end
   end

   // Counting never pauses between acquisitions
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // Time base counter (odd counter of the pair)
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         tb_count_ff <= '0;
      end else if (clear_now) begin
         tb_count_ff <= '0;
      end else if (tb_tick) begin
         tb_count_ff <= tb_count_ff + CNT_W'(1);
      end
   end

   // In frequency mode a source rise latches the running time base count
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         tb_latch_ff <= '0;
      end else if (clear_now) begin
         tb_latch_ff <= '0;
      end else if (mode == MECNT_FREQ && a_rise) begin
         tb_latch_ff <= tb_count_ff;
      end
   end

   // Period count: ticks between source rises, restart at each rise.
   // The first rise after reset only arms, since its interval is partial.
   // A tick in the cycle of a rise is dropped; the loss stays inside the
   // one-tick phase uncertainty that any period count carries anyway
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         period_ff <= '0;
         period_latch_ff <= '0;
         period_armed_ff <= 1'b0;
      end else if (clear_now || mode != MECNT_PERIOD) begin
         period_ff <= '0;
         period_latch_ff <= '0;
         period_armed_ff <= 1'b0;
      end else if (a_rise) begin
         period_ff <= '0;
         period_armed_ff <= 1'b1;
         if (period_armed_ff) begin
            period_latch_ff <= period_ff;
         end
      end else if (tb_tick) begin
         period_ff <= period_ff + CNT_W'(1);
      end
   end

   // New value flag: set on a completed period, cleared by the sample;
   // a completion in the sample cycle itself wins over the clear
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         period_new_ff <= 1'b0;
      end else if (mode == MECNT_PERIOD && a_rise && period_armed_ff && !clear_now) begin
         period_new_ff <= 1'b1;
      end else if (smp_tick || clear_now) begin
         period_new_ff <= 1'b0;
      end
   end

   // Sample capture; the live counters are only read, never disturbed
   // Outputs change only here, so the acquisition side always sees one
   // coherent pair of values per sample, never a half-updated one
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         count_out <= '0;
         time_out <= '0;
         sample_valid_out <= 1'b0;
      end else begin
         sample_valid_out <= smp_tick;
         if (smp_tick) begin
            case (mode)
               MECNT_FREQ: begin
                  count_out <= count_ff;
                  time_out <= tb_latch_ff;
               end
               MECNT_PERIOD: begin
                  time_out <= '0;
                  if (period_new_ff || !zero_opt) begin
                     count_out <= period_latch_ff;
                  end else begin
                     count_out <= '0;
                  end
               end
               default: begin
                  count_out <= count_ff;
                  time_out <= '0;
               end
            endcase
         end
      end
   end
endmodule

// ---- inc/mecnt_pkg.sv ----
// Constants, field layout and mode codes for the multimode encoder counter
package mecnt_pkg;
   localparam int CNT_W = 32;
   localparam int ADDR_W = 4;
   // Register offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] COUNT_OFS = 4'h4;
   localparam logic [3:0] TIME_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hc;
   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_FILT_LSB = 4;
   localparam int CTRL_DOWN_BIT = 8;
   localparam int CTRL_NOCLR_BIT = 9;
   localparam int CTRL_ZERO_BIT = 10;
   localparam int CTRL_INDEX_BIT = 11;
   localparam logic [11:0] CTRL_RESET = 12'h000;
   // Clock rates in kHz, periods in ps
   localparam int CLK_KHZ = 250000;
   localparam int TB_KHZ = 80000;
   localparam int TB_PERIOD_PS = 12500;
   // Filter gate times in ns, off first
   localparam int GATE_NS [8] = '{0, 100, 200, 500, 1000, 2000, 4000, 5000};
   localparam int GATE_W = 9;
   typedef enum logic [2:0] {
      MECNT_SINGLE = 3'b000,
      MECNT_DOUBLE = 3'b001,
      MECNT_QUAD = 3'b010,
      MECNT_PULSE = 3'b011,
      MECNT_FREQ = 3'b100,
      MECNT_PERIOD = 3'b101
   } mecnt_mode_e;
endpackage
